// >>> sdp_pkg.sv
// Behaviour
// - All pins are captured only on the rising clock edge.
// - Output data registers clock on each edge with clock enable and gate high; the burst counter steps only on such edges in the run state.
// - Clock gate low gives power-down, self refresh or clock suspend by state.
// - Clock gate is synchronous, and is sampled on the rising edge while powered down too.
// - Power-down and self refresh ignore all other memory pins; the register bus still takes reads and writes.
// - Select low enables the command decoder; select high masks every command.
// - Bursts under way and byte masking continue while select is high.
// - Command comes from select, row, column and write strobes on one edge.
// - A byte mask high during a write keeps that byte out of the array.
// - A byte mask high during a read floats that byte two clocks later.
// - Mask bit n governs data byte n; each of the four has its own state.
// - Two-bit bank select picks the bank for open, read, write, close.
// - Address is row on open-row; low eight bits are column on access.
// - Address bit 10 on read or write selects auto precharge.
// - On close-row, bit 10 high closes all banks, low only the selected.
// - Set-config command loads the opcode from the address inputs.
// - One shared 32-bit data bus, driven by the device only for reads.
// - Auto precharge closes the row when the burst ends.
package sdp_pkg;
   // Bus and array geometry
   localparam int unsigned DATA_W = 32;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned LANES = 4;
   localparam int unsigned MEM_AW = 8;
   localparam int unsigned MEM_WORDS = 256;
   localparam int unsigned PRE_BIT = 10;
   localparam int unsigned DQM_LAT = 2;
   // Register byte offsets and reset values
   localparam logic [3:0] REG_STATUS = 4'h0;
   localparam logic [3:0] REG_MODE = 4'h4;
   localparam logic [3:0] REG_CTRL = 4'h8;
   localparam logic [11:0] MODE_RST = 12'h000;
   localparam logic CMD_EN_RST = 1'b1;
   // Status field positions
   localparam int unsigned ST_PWR_LSB = 0;
   localparam int unsigned ST_OPEN_LSB = 8;
   localparam int unsigned ST_BURST = 12;
   localparam int unsigned ST_WRITE = 13;
   // Burst length field of the mode word
   localparam logic [2:0] BL_FULL = 3'h7;
   localparam logic [8:0] PAGE_LEN = 9'h100;

   // Commands, coded as {select, row, column, write} strobes
   typedef enum logic [3:0] {
      CMD_CFG = 4'h0,
      CMD_REF = 4'h1,
      CMD_PRE = 4'h2,
      CMD_ACT = 4'h3,
      CMD_WR = 4'h4,
      CMD_RD = 4'h5,
      CMD_BST = 4'h6,
      CMD_NOP = 4'h7,
      CMD_DESEL = 4'h8
   } sdp_cmd_t;

   // Power states
   typedef enum logic [4:0] {
      PW_RUN = 5'h01,
      PW_SUSP = 5'h02,
      PW_APD = 5'h04,
      PW_PPD = 5'h08,
      PW_SREF = 5'h10
   } sdp_pwr_t;

   // Command pins sampled together
   typedef struct packed {
      logic cs_b;
      logic ras_b;
      logic cas_b;
      logic we_b;
      logic [1:0] ba;
      logic [11:0] addr;
   } sdp_cmd_pins_t;
endpackage

// >>> sdp_pin_cmd.sv
`timescale 1ns/1ps
`default_nettype none
module sdp_pin_cmd
   import sdp_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic ce,
   // Memory pins
   input wire logic cke,
   input wire sdp_cmd_pins_t pins,
   input wire logic [3:0] byte_mask,
   input wire logic [31:0] dq_in,
   output logic [31:0] dq_out,
   output logic [3:0] dq_oe,
   // Avalon-MM slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   ////////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic sdp_cmd_t sdp_decode(input sdp_cmd_pins_t p);
      if (p.cs_b)
         return CMD_DESEL;
      return sdp_cmd_t'({1'b0, p.ras_b, p.cas_b, p.we_b});
   endfunction

   function automatic logic [MEM_AW-1:0] sdp_idx(input logic [1:0] b,
      input logic [11:0] r, input logic [7:0] c);
      return {b, r[1:0], c[3:0]};
   endfunction

   function automatic logic [8:0] sdp_blen(input logic [2:0] code);
      case (code)
         3'h0: return 9'h001;
         3'h1: return 9'h002;
         3'h2: return 9'h004;
         3'h3: return 9'h008;
         BL_FULL: return PAGE_LEN;
         default: return 9'h001;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // State
   // Array is never reset; only the current access writes it
   logic [DATA_W-1:0] mem [MEM_WORDS];
   sdp_pwr_t pw_q, pw_d;
   logic [3:0] open_q, open_d;
   logic [11:0] row_q [4];
   logic [11:0] row_d [4];
   logic [11:0] mode_q, mode_d;
   logic bst_q, bst_d, wr_q, wr_d, ap_q, ap_d;
   logic [1:0] bank_q, bank_d;
   logic [7:0] col_q, col_d;
   logic [8:0] cnt_q, cnt_d;
   logic rv_q, rv_d;
   logic [3:0] m1_q, m1_d;
   logic [31:0] rd_q, rd_d;
   logic [31:0] dq_out_d;
   logic [3:0] dq_oe_d;
   logic cmd_en_q, cmd_en_d;
   logic wait_q, wait_d;
   logic [31:0] rdata_q, rdata_d;
   sdp_cmd_t cmd;
   logic run, go, new_acc, acc, a_wr, a_last;
   logic [1:0] a_bank;
   logic [7:0] a_col;
   logic [MEM_AW-1:0] a_idx;

   // Command decode and gating
   always_comb begin
      cmd = sdp_decode(pins);
      run = ce && cke && (pw_q == PW_RUN);
      go = run && cmd_en_q && (cmd != CMD_DESEL);
      new_acc = go && (cmd == CMD_RD || cmd == CMD_WR);
      acc = new_acc || (run && bst_q);
      a_bank = new_acc ? pins.ba : bank_q;
      a_col = new_acc ? pins.addr[7:0] : col_q;
      a_wr = new_acc ? (cmd == CMD_WR) : wr_q;
      a_idx = sdp_idx(a_bank, row_q[a_bank], a_col);
      a_last = acc && (new_acc ? (sdp_blen(mode_q[2:0]) == 9'h001) : (cnt_q == 9'h001));
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power state next value
   always_comb begin
      pw_d = pw_q;
      if (ce) begin
         unique case (pw_q)
            PW_RUN: begin
               if (!cke) begin
                  if (bst_q)
                     pw_d = PW_SUSP;
                  else if (open_q != 4'h0)
                     pw_d = PW_APD;
                  else if (cmd_en_q && cmd == CMD_REF)
                     pw_d = PW_SREF;
                  else
                     pw_d = PW_PPD;
               end
            end
            PW_SUSP: if (cke) pw_d = PW_RUN;
            // Raw gate level wakes the part; nothing else is looked at
            PW_APD, PW_PPD, PW_SREF: if (cke) pw_d = PW_RUN;
            default: pw_d = PW_RUN;
         endcase
      end
   end

   // Bank, burst and mode next values
   always_comb begin
      open_d = open_q;
      row_d = row_q;
      mode_d = mode_q;
      bst_d = bst_q;
      wr_d = wr_q;
      ap_d = ap_q;
      bank_d = bank_q;
      col_d = col_q;
      cnt_d = cnt_q;
      if (go) begin
         unique case (cmd)
            CMD_ACT: begin
               open_d[pins.ba] = 1'b1;
               row_d[pins.ba] = pins.addr;
            end
            CMD_PRE: begin
               if (pins.addr[PRE_BIT])
                  open_d = 4'h0;
               else
                  open_d[pins.ba] = 1'b0;
            end
            CMD_CFG: mode_d = pins.addr;
            CMD_BST: bst_d = 1'b0;
            default: ;
         endcase
      end
      // Burst counter steps once per running edge
      if (acc) begin
         if (new_acc) begin
            wr_d = (cmd == CMD_WR);
            ap_d = pins.addr[PRE_BIT];
            bank_d = pins.ba;
            cnt_d = sdp_blen(mode_q[2:0]) - 9'h001;
         end else begin
            cnt_d = cnt_q - 9'h001;
         end
         col_d = a_col + 8'h01;
         bst_d = !a_last;
         if (a_last && (new_acc ? pins.addr[PRE_BIT] : ap_q))
            open_d[a_bank] = 1'b0;
      end
   end

   // Read pipeline and pin drivers
   always_comb begin
      rv_d = rv_q;
      m1_d = m1_q;
      rd_d = rd_q;
      dq_out_d = dq_out;
      dq_oe_d = dq_oe;
      // Frozen while the gate is low, so a suspended read keeps its word
      if (ce && cke) begin
         rv_d = acc && !a_wr;
         m1_d = byte_mask;
         rd_d = mem[a_idx];
         dq_out_d = rd_q;
         dq_oe_d = {LANES{rv_q}} & ~m1_q;
      end
   end

   // Register bus next values
   always_comb begin
      cmd_en_d = cmd_en_q;
      wait_d = wait_q;
      rdata_d = rdata_q;
      if (ce) begin
         wait_d = !((avs_read || avs_write) && wait_q);
         if (avs_write && !wait_q && avs_address == REG_CTRL && avs_byteenable[0])
            cmd_en_d = avs_writedata[0];
         if (avs_read && wait_q) begin
            rdata_d = 32'h0000_0000;
            unique case (avs_address)
               REG_STATUS: begin
                  rdata_d[ST_PWR_LSB +: 5] = pw_q;
                  rdata_d[ST_OPEN_LSB +: 4] = open_q;
                  rdata_d[ST_BURST] = bst_q;
                  rdata_d[ST_WRITE] = wr_q;
               end
               REG_MODE: rdata_d[11:0] = mode_q;
               REG_CTRL: rdata_d[0] = cmd_en_q;
               default: rdata_d = 32'h0000_0000;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         pw_q <= PW_RUN;
         open_q <= 4'h0;
         row_q <= '{default: 12'h000};
         mode_q <= MODE_RST;
         bst_q <= 1'b0;
         wr_q <= 1'b0;
         ap_q <= 1'b0;
         bank_q <= 2'h0;
         col_q <= 8'h00;
         cnt_q <= 9'h000;
         rv_q <= 1'b0;
         m1_q <= 4'hF;
         rd_q <= 32'h0000_0000;
         dq_out <= 32'h0000_0000;
         dq_oe <= 4'h0;
         cmd_en_q <= CMD_EN_RST;
         wait_q <= 1'b1;
         rdata_q <= 32'h0000_0000;
      end else if (ce) begin
         pw_q <= pw_d;
         open_q <= open_d;
         row_q <= row_d;
         mode_q <= mode_d;
         bst_q <= bst_d;
         wr_q <= wr_d;
         ap_q <= ap_d;
         bank_q <= bank_d;
         col_q <= col_d;
         cnt_q <= cnt_d;
         rv_q <= rv_d;
         m1_q <= m1_d;
         rd_q <= rd_d;
         dq_out <= dq_out_d;
         dq_oe <= dq_oe_d;
         cmd_en_q <= cmd_en_d;
         wait_q <= wait_d;
         rdata_q <= rdata_d;
      end
   end

   assign avs_waitrequest = wait_q;
   assign avs_readdata = rdata_q;

   // Array write, masked lanes left untouched
   always_ff @(posedge core_clk) begin
      if (acc && a_wr) begin
         for (int i = 0; i < LANES; i++) begin
            if (!byte_mask[i])
               mem[a_idx][8*i +: 8] <= dq_in[8*i +: 8];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   AST_CS_MASK: assert property (run && pins.cs_b && !bst_q
         |=> $stable(open_q) && $stable(mode_q))
      else $error("deselected command changed state");
   AST_BURST_CONT: assert property (run && bst_q && pins.cs_b
         |=> cnt_q == $past(cnt_q) - 9'h001 && col_q == $past(col_q) + 8'h01)
      else $error("burst did not step while deselected");
   AST_PRE_ALL: assert property (go && cmd == CMD_PRE && pins.addr[PRE_BIT] && !acc
         |=> open_q == 4'h0)
      else $error("precharge all left a bank open");
   AST_PRE_ONE: assert property (go && cmd == CMD_PRE && !pins.addr[PRE_BIT]
         |=> !open_q[$past(pins.ba)])
      else $error("precharge left selected bank open");
   AST_ACT: assert property (go && cmd == CMD_ACT |=> open_q[$past(pins.ba)] &&
         row_q[$past(pins.ba)] == $past(pins.addr))
      else $error("open row not recorded");
   AST_CFG: assert property (go && cmd == CMD_CFG |=> mode_q == $past(pins.addr))
      else $error("config opcode not taken");
   AST_DQM_LAT: assert property (ce && cke && byte_mask[0] ##1 ce && cke
         |=> !dq_oe[0])
      else $error("masked lane driven");
   AST_SUSPEND: assert property (ce && !cke && pw_q == PW_RUN && bst_q
         |=> pw_q == PW_SUSP)
      else $error("no clock suspend during burst");
   AST_PD_EXIT: assert property (ce && cke && pw_q inside {PW_APD, PW_PPD, PW_SREF}
         |=> pw_q == PW_RUN)
      else $error("power-down not left");
   AST_PD_DEAF: assert property (ce && pw_q == PW_PPD
         |=> $stable(open_q) && $stable(mode_q))
      else $error("inputs heard in power-down");
   AST_AUTOPRE: assert property (run && bst_q && !new_acc && cnt_q == 9'h001 && ap_q
         |=> !open_q[$past(bank_q)])
      else $error("auto precharge missed");

   // Main scenarios
   COV_READ: cover property (new_acc && cmd == CMD_RD ##2 dq_oe != 4'h0);
   COV_WRITE: cover property (new_acc && cmd == CMD_WR && byte_mask != 4'h0);
   COV_SREF: cover property (pw_q == PW_RUN ##1 pw_q == PW_SREF);
   COV_SUSP: cover property (pw_q == PW_SUSP ##1 pw_q == PW_RUN);
   COV_DESEL_BURST: cover property (run && bst_q && pins.cs_b);
endmodule
`default_nettype wire

// >>> sdp_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
module sdp_ctl_model
   import sdp_pkg::*;
(
   // Clock
   input wire logic core_clk,
   // Pins toward the device
   output logic cke,
   output sdp_cmd_pins_t pins,
   output logic [3:0] byte_mask,
   output logic [31:0] dq_in
);
   ////////////////////////////////////////
   // Deselected until the sequence starts
   initial begin
      cke = 1'b1;
      pins = {CMD_DESEL, 14'h0000};
      byte_mask = 4'h0;
      dq_in = 32'hA5A5A5A5;
   end
   // One command, all strobes on one edge
   task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a,
         input logic [3:0] m, input logic [31:0] d);
      @(posedge core_clk);
      pins <= {c, b, a};
      byte_mask <= m;
      dq_in <= d;
   endtask
   // Idle cycles; released data lines toggle
   task automatic nop(input int n);
      repeat (n) begin
         @(posedge core_clk);
         pins <= {CMD_NOP, 14'h0000};
         byte_mask <= 4'h0;
         dq_in <= ~dq_in;
      end
   endtask
   // Clock gate level
   task automatic gate(input logic v);
      @(posedge core_clk);
      cke <= v;
   endtask
endmodule
`default_nettype wire

// >>> tb_sdram_pin_command_interface.sv
`timescale 1ns/1ps
`default_nettype none
module tb_sdram_pin_command_interface
   import sdp_pkg::*;
;
   logic core_clk, rst_b, ce, cke;
   sdp_cmd_pins_t pins;
   logic [3:0] byte_mask, dq_oe, avs_address, avs_byteenable;
   logic [31:0] dq_in, dq_out, avs_writedata, avs_readdata;
   logic avs_read, avs_write, avs_waitrequest;
   int errors, samples_checked, cycles, seed;
   logic [31:0] d [6];
   logic [35:0] e;
   logic [35:0] rd_q [$];
   logic [31:0] rg_q [$];
   logic [3:0] be_next;
   ////////////////////////////////////////
   // Device and controller model
   sdp_pin_cmd u_sdp_pin_cmd (.core_clk(core_clk), .rst_b(rst_b), .ce(ce), .cke(cke),
      .pins(pins), .byte_mask(byte_mask), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
   sdp_ctl_model u_sdp_ctl_model (.core_clk(core_clk), .cke(cke), .pins(pins),
      .byte_mask(byte_mask), .dq_in(dq_in));
   // Clock
   initial core_clk = 1'b0;
   always #20 core_clk = ~core_clk;
   ////////////////////////////////////////
   function automatic logic [31:0] lanes(input logic [3:0] m);
      lanes = {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
   endfunction
   // Compare and count
   task automatic check(input string nm, input logic [35:0] seen, input logic [35:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Register access; read expectation queued first
   task automatic av(input logic w, input logic [3:0] a, input logic [31:0] dv);
      if (!w) rg_q.push_back(dv);
      @(posedge core_clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= dv;
      avs_byteenable <= be_next;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   // Clock enable low: a command on the pins must be lost
   task automatic freeze_act(input int n);
      @(posedge core_clk);
      ce <= 1'b0;
      u_sdp_ctl_model.issue(CMD_ACT, 2'h0, 12'h000, 4'h0, 32'h0);
      u_sdp_ctl_model.nop(n);
      ce <= 1'b1;
   endtask
   ////////////////////////////////////////
   // Watcher: oldest note against each result
   always @(posedge core_clk) begin
      cycles++;
      if (rst_b === 1'b1 && dq_oe !== 4'h0) begin
         e = (rd_q.size() > 0) ? rd_q.pop_front() : 36'h0;
         e[31:0] = e[31:0] & lanes(e[35:32]);
         check("dq", {dq_oe, dq_out & lanes(dq_oe)}, e);
      end
      if (avs_read && avs_waitrequest === 1'b0) begin
         check("rdata", 36'(avs_readdata), 36'(rg_q.pop_front()));
      end
      if (cycles > 2000) begin
         errors++;
         final_report();
      end
   end
   // Main sequence
   initial begin
      seed = 32'h5C1AD50A;
      rst_b = 1'b0;
      ce = 1'b1;
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
      be_next = 4'hF;
      errors = 0;
      samples_checked = 0;
      cycles = 0;
      for (int i = 0; i < 6; i++) d[i] = $random(seed);
      repeat (12) @(posedge core_clk);
      rst_b <= 1'b1;
      av(0, REG_CTRL, 32'(CMD_EN_RST));
      av(0, REG_STATUS, 32'h1);
      av(0, 4'hC, 32'h0);
      // Control write with lane 0 disabled is ignored
      be_next = 4'($random(seed)) & 4'hE;
      av(1, REG_CTRL, 32'($random(seed)) & 32'hFFFF_FFFE);
      be_next = 4'hF;
      av(0, REG_CTRL, 32'h1);
      u_sdp_ctl_model.issue(CMD_ACT, 2'h1, 12'h002, 4'h0, 32'h0);
      u_sdp_ctl_model.issue(CMD_WR, 2'h1, 12'h004, 4'h0, d[0]);
      u_sdp_ctl_model.issue(CMD_WR, 2'h1, 12'h005, 4'h0, d[1]);
      u_sdp_ctl_model.issue(CMD_WR, 2'h1, 12'h005, 4'h2, d[2]);
      u_sdp_ctl_model.issue(4'hC, 2'h1, 12'h004, 4'h0, d[3]);
      rd_q.push_back({4'hF, d[0]});
      u_sdp_ctl_model.issue(CMD_RD, 2'h1, 12'h004, 4'h0, 32'h0);
      rd_q.push_back({4'h6, (d[2] & 32'hFFFF00FF) | (d[1] & 32'h0000FF00)});
      u_sdp_ctl_model.issue(CMD_RD, 2'h1, 12'h005, 4'h9, 32'h0);
      u_sdp_ctl_model.nop(4);
      av(1, REG_CTRL, 32'h0);
      u_sdp_ctl_model.issue(CMD_ACT, 2'h0, 12'h000, 4'h0, 32'h0);
      u_sdp_ctl_model.nop(2);
      av(1, REG_CTRL, 32'h1);
      av(0, REG_STATUS, 32'h201);
      u_sdp_ctl_model.gate(1'b0);
      u_sdp_ctl_model.nop(2);
      av(0, REG_STATUS, 32'h204);
      u_sdp_ctl_model.gate(1'b1);
      u_sdp_ctl_model.nop(2);
      av(0, REG_STATUS, 32'h201);
      u_sdp_ctl_model.issue(CMD_ACT, 2'h2, 12'h001, 4'h0, 32'h0);
      u_sdp_ctl_model.issue(CMD_PRE, 2'h1, 12'h000, 4'h0, 32'h0);
      u_sdp_ctl_model.nop(2);
      av(0, REG_STATUS, 32'h401);
      u_sdp_ctl_model.issue(CMD_PRE, 2'h0, 12'h400, 4'h0, 32'h0);
      u_sdp_ctl_model.nop(2);
      u_sdp_ctl_model.gate(1'b0);
      u_sdp_ctl_model.nop(2);
      u_sdp_ctl_model.issue(CMD_ACT, 2'h0, 12'h000, 4'h0, 32'h0);
      u_sdp_ctl_model.nop(1);
      av(0, REG_STATUS, 32'h8);
      u_sdp_ctl_model.gate(1'b1);
      u_sdp_ctl_model.nop(2);
      av(0, REG_STATUS, 32'h1);
      u_sdp_ctl_model.issue(CMD_CFG, 2'h0, 12'h001, 4'h0, 32'h0);
      u_sdp_ctl_model.nop(1);
      av(1, REG_MODE, $random(seed));
      av(0, REG_MODE, 32'h1);
      u_sdp_ctl_model.issue(CMD_ACT, 2'h3, 12'h000, 4'h0, 32'h0);
      u_sdp_ctl_model.issue(CMD_WR, 2'h3, 12'h008, 4'h0, d[4]);
      u_sdp_ctl_model.issue(CMD_DESEL, 2'h0, 12'h000, 4'h0, d[5]);
      rd_q.push_back({4'hF, d[4]});
      rd_q.push_back({4'hF, d[5]});
      u_sdp_ctl_model.issue(CMD_RD, 2'h3, 12'h408, 4'h0, 32'h0);
      u_sdp_ctl_model.issue(CMD_DESEL, 2'h0, 12'h000, 4'h0, 32'h0);
      u_sdp_ctl_model.nop(4);
      av(0, REG_STATUS, 32'h1);
      // Clock suspend in mid burst keeps both words in order
      rd_q.push_back({4'hF, d[4]});
      rd_q.push_back({4'hF, d[5]});
      u_sdp_ctl_model.issue(CMD_ACT, 2'h3, 12'h000, 4'h0, 32'h0);
      u_sdp_ctl_model.issue(CMD_RD, 2'h3, 12'h008, 4'h0, 32'h0);
      u_sdp_ctl_model.gate(1'b0);
      av(0, REG_STATUS, 32'h1802);
      u_sdp_ctl_model.gate(1'b1);
      u_sdp_ctl_model.nop(4);
      av(0, REG_STATUS, 32'h801);
      freeze_act(($random(seed) & 3) + 1);
      av(0, REG_STATUS, 32'h801);
      check("pending", 36'(rd_q.size()), 36'h0);
      final_report();
   end
endmodule
`default_nettype wire
